// ---- core/qpc_pkg.sv ----
// Package: constants and types of the quad pot serial command unit
package qpc_pkg;
    localparam int CLK_MHZ = 100;
    // Times in their own units
    localparam int NV_WRITE_MS = 10;
    localparam int WIPER_LOAD_US = 10;
    localparam int WIPER_STEP_US = 10;
    localparam int POWERUP_SETTLE_US = 10;
    localparam int POWERUP_READ_MS = 1;
    localparam int POWERUP_WRITE_MS = 5;
    // Times in cycles (longest time is exact, no rounding)
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
    localparam int WIPER_LOAD_CYC = WIPER_LOAD_US * CLK_MHZ;
    localparam int WIPER_STEP_CYC = WIPER_STEP_US * CLK_MHZ;
    localparam int POWERUP_SETTLE_CYC = POWERUP_SETTLE_US * CLK_MHZ;
    // Frame layout
    localparam logic [3:0] DEV_TYPE = 4'h5;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_RD_STORED = 4'hB;
    localparam logic [3:0] OP_WR_STORED = 4'hC;
    localparam logic [3:0] OP_COPY_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_SAVE_WIPER = 4'hE;
    localparam logic [3:0] OP_GLOBAL_RESTORE = 4'h1;
    localparam logic [3:0] OP_GLOBAL_SAVE = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [7:0] STORED_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INSTR = 3'b010,
        ST_DATA = 3'b011,
        ST_STEP = 3'b100,
        ST_IGNORE = 3'b101
    } qpc_state_e;

    typedef enum logic [2:0] {
        NV_NONE = 3'b000,
        NV_WR_STORED = 3'b001,
        NV_SAVE = 3'b010,
        NV_GSAVE = 3'b011
    } qpc_nv_e;
endpackage

// ---- core/qpc_nv_if.sv ----
// Interface: request and status between command decoder and storage engine
`timescale 1ns/10ps
interface qpc_nv_if;
    logic start;
    qpc_pkg::qpc_nv_e kind;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
    logic [7:0] data;
    logic busy;
    logic done;
    modport ctrl (output start, output kind, output reg_sel, output pot_sel, output data,
        input busy, input done);
    modport eng (input start, input kind, input reg_sel, input pot_sel, input data,
        output busy, output done);
endinterface

// ---- core/qpc_nv_timer.sv ----
// Storage engine timer: holds busy for the nonvolatile programming time
`timescale 1ns/10ps
module qpc_nv_timer #(
    parameter int NV_CYC = qpc_pkg::NV_WRITE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    qpc_nv_if.eng nv
);
    import qpc_pkg::*;
    logic [23:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire cnt_end = (cnt_q == 24'(NV_CYC - 1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 24'h000000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= busy_q && cnt_end;
            if (nv.start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= 24'h000000;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 24'h000001;
                if (cnt_end) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end
    assign nv.busy = busy_q;
    assign nv.done = done_q;
endmodule

// ---- core/qpc_core.sv ----
// Quad pot serial command unit: 2-wire slave, decoder, wiper and stored settings
`timescale 1ns/10ps
// How it works
// - Stored write: addr, 1100 instr, data, stop
// - Stop after stored write starts programming
// - Copy op 1101 loads wiper, no cycle
// - Save 1110 stores wiper, cycle after stop
// - Step 0010 then up/down pulses until stop
// - Global restore 0001 loads all wipers
// - Global save 1000 stores all wipers
// - Programming cycle ends within 10 ms
// - Loaded wiper shows within 10 us
// - Each step shows within 10 us
// - Recalled wiper shows within 10 us
// - Recall waits for all supplies stable
// - Data high steps up, low down
// - Power-up loads wiper from setting zero
module qpc_core #(
    parameter int NV_CYC = qpc_pkg::NV_WRITE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address straps
    input wire logic [3:0] strap_addr,
    // Supply monitor, high once all three supplies are stable
    input wire logic supplies_good,
    // Wiper outputs, one byte per pot
    output logic [31:0] wiper_pos,
    // Status
    output logic nv_busy,
    output logic recall_done
);
    import qpc_pkg::*;

    qpc_nv_if nv ();
    qpc_nv_timer #(.NV_CYC(NV_CYC)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .nv(nv)
    );

    // Two-stage synchronisers
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [1:0] pg_s_q;
    logic [3:0] strap_m_q;
    logic [3:0] strap_s_q;
    logic scl_d1_q;
    logic sda_d1_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            pg_s_q <= 2'h0;
            strap_m_q <= 4'h0;
            strap_s_q <= 4'h0;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            pg_s_q <= {pg_s_q[0], supplies_good};
            strap_m_q <= strap_addr;
            strap_s_q <= strap_m_q;
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
        end
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl && !scl_d1_q;
    wire scl_fall = !scl && scl_d1_q;
    wire start_cond = scl && scl_d1_q && sda_d1_q && !sda;
    wire stop_cond = scl && scl_d1_q && !sda_d1_q && sda;

    // Register storage
    logic [7:0] wiper_q [4];
    logic [7:0] stored_q [16];

    function automatic logic [3:0] sidx(input logic [1:0] pot, input logic [1:0] rsel);
        sidx = {pot, rsel};
    endfunction

    // Frame state
    qpc_state_e state_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic ack_phase_q;
    logic ack_drive_q;
    logic [7:0] instr_q;
    logic [7:0] data_q;
    logic data_ok_q;
    logic step_dir_q;
    logic step_go_q;
    logic step_pend_q;
    logic bit_seen_q;
    wire [7:0] shift_next = {shift_q[6:0], sda};
    wire [3:0] op = instr_q[7:4];
    wire [1:0] rsel = instr_q[3:2];
    wire [1:0] psel = instr_q[1:0];
    wire busy = nv.busy || nv.start;

    // Power-up recall sequencing
    logic recall_q;
    logic [1:0] recall_pot_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            recall_q <= 1'b0;
            recall_pot_q <= 2'h0;
        end else if (pg_s_q[1] && !recall_q) begin
            recall_pot_q <= recall_pot_q + 2'h1;
            if (recall_pot_q == 2'h3) begin
                recall_q <= 1'b1;
            end
        end
    end
    wire recall_busy = !recall_q;

    // Serial frame engine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            instr_q <= 8'h00;
            data_q <= 8'h00;
            data_ok_q <= 1'b0;
            step_dir_q <= 1'b0;
            step_go_q <= 1'b0;
            step_pend_q <= 1'b0;
        end else begin
            step_go_q <= 1'b0;
            if (start_cond) begin
                state_q <= ST_ADDR;
                bit_q <= 3'h0;
                ack_phase_q <= 1'b0;
                ack_drive_q <= 1'b0;
                data_ok_q <= 1'b0;
                // Opcode zero is no operation, so a refused frame cannot replay the last one
                instr_q <= 8'h00;
                step_pend_q <= 1'b0;
            end else if (stop_cond) begin
                state_q <= ST_IDLE;
                ack_drive_q <= 1'b0;
                step_pend_q <= 1'b0;
            end else if (scl_fall && ack_phase_q) begin
                // Ack bit clocked out, release bus
                ack_phase_q <= 1'b0;
                ack_drive_q <= 1'b0;
            end else if (scl_rise && !ack_phase_q) begin
                case (state_q)
                    ST_ADDR, ST_INSTR, ST_DATA: begin
                        shift_q <= shift_next;
                        bit_q <= bit_q + 3'h1;
                    end
                    ST_STEP: begin
                        step_dir_q <= sda;
                        step_pend_q <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall && state_q == ST_STEP) begin
                // Step lands when the pulse ends, so the high phase of a stop never steps
                step_go_q <= step_pend_q;
                step_pend_q <= 1'b0;
            end else if (scl_fall && bit_q == 3'h0 && state_q != ST_IDLE
                && state_q != ST_STEP && state_q != ST_IGNORE && bit_seen_q) begin
                // Eighth bit done: decide ack and next state
                case (state_q)
                    ST_ADDR: begin
                        if (shift_q[7:4] == DEV_TYPE && shift_q[3:0] == strap_s_q
                            && !busy && !recall_busy) begin
                            ack_phase_q <= 1'b1;
                            ack_drive_q <= 1'b1;
                            state_q <= ST_INSTR;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_INSTR: begin
                        instr_q <= shift_q;
                        ack_phase_q <= 1'b1;
                        ack_drive_q <= 1'b1;
                        if (shift_q[7:4] == OP_WR_STORED || shift_q[7:4] == OP_WR_WIPER) begin
                            state_q <= ST_DATA;
                        end else if (shift_q[7:4] == OP_STEP) begin
                            state_q <= ST_STEP;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_DATA: begin
                        data_q <= shift_q;
                        data_ok_q <= 1'b1;
                        ack_phase_q <= 1'b1;
                        ack_drive_q <= 1'b1;
                        state_q <= ST_IGNORE;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Tracks that a byte has at least started, so bit count zero means complete
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_seen_q <= 1'b0;
        end else if (start_cond || (scl_fall && bit_q == 3'h0)) begin
            bit_seen_q <= 1'b0;
        end else if (scl_rise && !ack_phase_q) begin
            bit_seen_q <= 1'b1;
        end
    end

    // Frame completion at stop: decide effect
    wire frame_end = stop_cond && (state_q == ST_IGNORE || state_q == ST_STEP);
    wire instr_ok = (state_q != ST_ADDR) && !recall_busy;
    wire do_write_wiper = frame_end && op == OP_WR_WIPER && data_ok_q;
    wire do_write_stored = frame_end && op == OP_WR_STORED && data_ok_q;
    wire do_copy = frame_end && op == OP_COPY_TO_WIPER;
    wire do_save = frame_end && op == OP_SAVE_WIPER;
    wire do_grestore = frame_end && op == OP_GLOBAL_RESTORE && psel == 2'h0;
    wire do_gsave = frame_end && op == OP_GLOBAL_SAVE && psel == 2'h0;
    wire nv_go = instr_ok && (do_write_stored || do_save || do_gsave);

    // Start request toward the storage engine, held one cycle
    logic nv_start_q;
    qpc_nv_e nv_kind_q;
    logic [1:0] nv_rsel_q;
    logic [1:0] nv_psel_q;
    logic [7:0] nv_data_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nv_start_q <= 1'b0;
            nv_kind_q <= NV_NONE;
            nv_rsel_q <= 2'h0;
            nv_psel_q <= 2'h0;
            nv_data_q <= 8'h00;
        end else begin
            nv_start_q <= nv_go;
            if (nv_go) begin
                nv_kind_q <= do_write_stored ? NV_WR_STORED : (do_save ? NV_SAVE : NV_GSAVE);
                nv_rsel_q <= rsel;
                nv_psel_q <= psel;
                nv_data_q <= data_q;
            end
        end
    end
    assign nv.start = nv_start_q;
    assign nv.kind = nv_kind_q;
    assign nv.reg_sel = nv_rsel_q;
    assign nv.pot_sel = nv_psel_q;
    assign nv.data = nv_data_q;

    // Wiper and stored-setting update; the byte commits when the cycle completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                wiper_q[i] <= WIPER_RESET;
            end
            for (int j = 0; j < 16; j++) begin
                stored_q[j] <= STORED_RESET;
            end
        end else begin
            if (recall_busy && pg_s_q[1]) begin
                wiper_q[recall_pot_q] <= stored_q[sidx(recall_pot_q, 2'h0)];
            end else if (step_go_q && state_q == ST_STEP) begin
                if (step_dir_q && wiper_q[psel] != 8'hFF) begin
                    wiper_q[psel] <= wiper_q[psel] + 8'h01;
                end else if (!step_dir_q && wiper_q[psel] != 8'h00) begin
                    wiper_q[psel] <= wiper_q[psel] - 8'h01;
                end
            end else if (instr_ok && do_write_wiper) begin
                wiper_q[psel] <= data_q;
            end else if (instr_ok && do_copy) begin
                wiper_q[psel] <= stored_q[sidx(psel, rsel)];
            end else if (instr_ok && do_grestore) begin
                for (int k = 0; k < 4; k++) begin
                    wiper_q[k] <= stored_q[sidx(2'(k), rsel)];
                end
            end
            if (nv.done) begin
                case (nv.kind)
                    NV_WR_STORED: stored_q[sidx(nv.pot_sel, nv.reg_sel)] <= nv.data;
                    NV_SAVE: stored_q[sidx(nv.pot_sel, nv.reg_sel)] <= wiper_q[nv.pot_sel];
                    NV_GSAVE: begin
                        for (int m = 0; m < 4; m++) begin
                            stored_q[sidx(2'(m), nv.reg_sel)] <= wiper_q[m];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Outputs; open-drain ack pulls the line low
    assign sda_out = 1'b0;
    assign sda_oe = ack_drive_q;
    assign wiper_pos = {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};
    assign nv_busy = nv.busy;
    assign recall_done = recall_q;
endmodule

// ---- tb/qpc_checker.sv ----
// Checker: port-level properties of the command unit
`timescale 1ns/10ps
module qpc_checker #(
    parameter int NV_CYC = 1000000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Straps and supplies
    input wire logic [3:0] strap_addr,
    input wire logic supplies_good,
    // Outputs
    input wire logic [31:0] wiper_pos,
    input wire logic nv_busy,
    input wire logic recall_done
);
    localparam int SETTLE_MAX = 1000;
    logic [31:0] busy_cnt_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Counts how long the programming cycle has run
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= nv_busy ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    sequence ack_rise;
        $rose(sda_oe);
    endsequence
    sequence ack_hold;
        sda_oe [*5];
    endsequence
    AST_ACK_HOLD: assert property (ack_rise |-> ack_hold)
        else $error("ack pulse too short");
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    AST_NV_BOUND: assert property (busy_cnt_q <= NV_CYC + 4)
        else $error("programming cycle too long");
    AST_NV_MIN: assert property ($rose(nv_busy) |=> nv_busy [*8])
        else $error("programming cycle cut short");
    AST_NO_ACK_BUSY: assert property (nv_busy |-> !$rose(sda_oe))
        else $error("ack while programming");
    AST_BUSY_WIPER: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_pos))
        else $error("wiper moved while programming");
    AST_NO_ACK_RECALL: assert property (!recall_done |-> !sda_oe)
        else $error("ack before recall");
    AST_RECALL_CAUSE: assert property ($rose(recall_done) |-> $past(supplies_good, 2))
        else $error("recall before supplies stable");
    AST_RECALL_TIME: assert property ($rose(supplies_good) && !recall_done
        |-> ##[1:SETTLE_MAX] recall_done)
        else $error("recall too slow");
endmodule

bind qpc_core qpc_checker #(.NV_CYC(NV_CYC)) i_qpc_checker (.sys_clk(sys_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_addr(strap_addr), .supplies_good(supplies_good), .wiper_pos(wiper_pos),
    .nv_busy(nv_busy), .recall_done(recall_done));

// ---- tb/qpc_host.sv ----
// Partner: host master on the 2-wire bus
`timescale 1ns/10ps
module qpc_host (
    // Clock
    input wire logic sys_clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Half of the 80 ns link period is four system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start_c();
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop_c();
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    // Data bit or single step pulse, level held through the high phase
    task automatic clk_bit(input logic b);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i]);
        end
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        ack = ~sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    // Shortened wait after supplies settle before the first frame
    task automatic ready_wait(input int n);
        tick(n);
    endtask
endmodule

// ---- tb/qpc_core_tb.sv ----
// Testbench: random and corner frames against the command unit
`timescale 1ns/10ps
module qpc_core_tb;
    import qpc_pkg::*;
    localparam int NV_SIM = 200;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic supplies_good = 1'b0;
    logic [3:0] strap_addr = 4'h0;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic nv_busy;
    logic recall_done;
    logic [31:0] wiper_pos;
    logic [7:0] exp_w [4];
    logic [7:0] exp_s [4][4];
    logic [7:0] adr;
    logic [7:0] d;
    logic [1:0] r;
    logic ack;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 22;
    // Open-drain data line with pull-up
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    always #5 sys_clk = ~sys_clk;
    qpc_core #(.NV_CYC(NV_SIM)) i_qpc_core (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr(strap_addr),
        .supplies_good(supplies_good), .wiper_pos(wiper_pos), .nv_busy(nv_busy),
        .recall_done(recall_done));
    qpc_host i_qpc_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic summarize();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] step_val(input logic [7:0] v, input logic up);
        if (up) begin
            return (v == 8'hFF) ? v : v + 8'h01;
        end
        return (v == 8'h00) ? v : v - 8'h01;
    endfunction
    task automatic chk_w();
        i_qpc_host.tick(20);
        chk(wiper_pos, {exp_w[3], exp_w[2], exp_w[1], exp_w[0]});
    endtask
    // Address byte, then instruction and optional data when addressed
    task automatic cmd(input logic [7:0] a, input logic [7:0] ins, input logic has_d,
        input logic [7:0] dat, input logic exp_ack);
        i_qpc_host.start_c();
        i_qpc_host.send_byte(a, ack);
        chk(ack, exp_ack);
        if (exp_ack) begin
            i_qpc_host.send_byte(ins, ack);
            chk(ack, 1'b1);
            if (has_d) begin
                i_qpc_host.send_byte(dat, ack);
                chk(ack, 1'b1);
            end
        end
        i_qpc_host.stop_c();
    endtask
    // Probe sends an address mid-cycle, which must go unanswered
    task automatic wait_nv(input logic exp_cyc, input logic probe);
        int n;
        n = 0;
        while (nv_busy !== 1'b1 && n < 20) begin
            i_qpc_host.tick(1);
            n++;
        end
        chk(nv_busy, exp_cyc);
        if (probe) begin
            cmd(adr, 8'h00, 1'b0, 8'h00, 1'b0);
        end
        n = 0;
        while (nv_busy !== 1'b0 && n < NV_SIM + 50) begin
            i_qpc_host.tick(1);
            n++;
        end
        chk(nv_busy, 1'b0);
    endtask
    task automatic set_w(input logic [1:0] p, input logic [7:0] v);
        cmd(adr, {OP_WR_WIPER, 2'b00, p}, 1'b1, v, 1'b1);
        exp_w[p] = v;
    endtask
    initial begin
        strap_addr = 4'($random(seed));
        adr = {DEV_TYPE, strap_addr};
        for (int i = 0; i < 16; i++) begin
            exp_s[i / 4][i % 4] = 8'h00;
            exp_w[i / 4] = 8'h00;
        end
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        i_qpc_host.tick(10);
        cmd(adr, 8'h00, 1'b0, 8'h00, 1'b0);
        chk(recall_done, 1'b0);
        supplies_good = 1'b1;
        i_qpc_host.tick(30);
        chk(recall_done, 1'b1);
        chk(wiper_pos, 32'h0);
        i_qpc_host.ready_wait(50);
        cmd({DEV_TYPE, ~strap_addr}, 8'h00, 1'b0, 8'h00, 1'b0);
        for (int p = 0; p < 4; p++) begin
            set_w(2'(p), 8'($random(seed)));
            r = 2'($random(seed));
            d = 8'($random(seed));
            cmd(adr, {OP_WR_STORED, r, 2'(p)}, 1'b1, d, 1'b1);
            exp_s[p][r] = d;
            wait_nv(1'b1, 1'b1);
            cmd(adr, {OP_COPY_TO_WIPER, r, 2'(p)}, 1'b0, 8'h00, 1'b1);
            exp_w[p] = exp_s[p][r];
            wait_nv(1'b0, 1'b0);
            chk_w();
            set_w(2'(p), 8'($random(seed)));
            r = 2'($random(seed));
            cmd(adr, {OP_SAVE_WIPER, r, 2'(p)}, 1'b0, 8'h00, 1'b1);
            exp_s[p][r] = exp_w[p];
            wait_nv(1'b1, 1'b0);
            set_w(2'(p), ~exp_w[p]);
            cmd(adr, {OP_COPY_TO_WIPER, r, 2'(p)}, 1'b0, 8'h00, 1'b1);
            exp_w[p] = exp_s[p][r];
            chk_w();
        end
        // Steps start next to either end so saturation is reached
        for (int s = 0; s < 2; s++) begin
            set_w(2'd2, s ? 8'h01 : 8'hFE);
            i_qpc_host.start_c();
            i_qpc_host.send_byte(adr, ack);
            i_qpc_host.send_byte({OP_STEP, 2'b00, 2'd2}, ack);
            chk(ack, 1'b1);
            for (int k = 0; k < 10; k++) begin
                d[0] = (k < 3) ? ~s[0] : ((k == 3) ? s[0] : 1'($random(seed)));
                i_qpc_host.clk_bit(d[0]);
                exp_w[2] = step_val(exp_w[2], d[0]);
                chk_w();
            end
            i_qpc_host.stop_c();
        end
        r = 2'($random(seed));
        cmd(adr, {OP_GLOBAL_SAVE, r, 2'b00}, 1'b0, 8'h00, 1'b1);
        for (int p = 0; p < 4; p++) begin
            exp_s[p][r] = exp_w[p];
        end
        wait_nv(1'b1, 1'b0);
        for (int p = 0; p < 4; p++) begin
            set_w(2'(p), 8'($random(seed)));
            exp_w[p] = exp_s[p][r];
        end
        cmd(adr, {OP_GLOBAL_RESTORE, r, 2'b00}, 1'b0, 8'h00, 1'b1);
        wait_nv(1'b0, 1'b0);
        chk_w();
        foreach (exp_s[i]) begin
            cmd(adr, {4'(3 + i), 4'($random(seed))}, 1'b0, 8'h00, 1'b1);
            wait_nv(1'b0, 1'b0);
            chk_w();
        end
        // Reset in mid-run with new straps: recall runs again, old address goes unanswered
        rst = 1'b1;
        strap_addr = ~strap_addr;
        i_qpc_host.tick(2);
        rst = 1'b0;
        i_qpc_host.tick(30);
        chk(recall_done, 1'b1);
        chk(wiper_pos, 32'h0);
        cmd(adr, 8'h00, 1'b0, 8'h00, 1'b0);
        adr = {DEV_TYPE, strap_addr};
        for (int p = 0; p < 4; p++) begin
            exp_w[p] = 8'h00;
        end
        set_w(2'd1, 8'($random(seed)));
        chk_w();
        summarize();
    end
    initial begin
        #600000;
        num_errors++;
        summarize();
    end
endmodule
